// File: clock_supervisor_pkg.sv
/*
  Package for the clock supervisor: register map, field positions,
  reset values, timing counts and shared types.
  Assumes a 32-bit AXI4-Lite register bus and a single core clock.
*/
`default_nettype none
package clock_supervisor_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_ADDR       = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h04;
  localparam logic [7:0] CONTROL_ADDR     = 8'h08;
  localparam logic [7:0] EVENT_CLEAR_ADDR = 8'h0C;
  localparam logic [7:0] STATE_ADDR       = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SELF_CLOCK_STATUS_BIT = 0;
  localparam int SELF_CLOCK_FLAG_BIT   = 1;
  localparam int PLL_LOCKED_FLAG_BIT   = 4;
  localparam int PERIODIC_FLAG_BIT     = 7;
  localparam int MONITOR_ENABLE_BIT    = 0;
  localparam int FALLBACK_ENABLE_BIT   = 1;
  localparam int PLL_OFF_IN_WAIT_BIT   = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int QUALITY_CHECK_CYCLES = 4096;
  localparam int QUALITY_COUNT_W      = 13;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic monitor_enable;
    logic fallback_enable;
    logic pll_off_in_wait;
  } clock_control_t;

  typedef struct packed {
    logic regulator_on;
    logic pll_on;
    logic use_pll_clock;
    logic in_wait;
  } power_out_t;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_FALLBACK_CHECK
  } supervise_state_t;

endpackage
`default_nettype wire

// File: clock_supervisor.sv
/*
  Clock-loss supervisor with self-clock fallback, wait-mode sequencing,
  clock interrupt enables and an AXI4-Lite register slave.
  Assumes the crystal status, wait and wakeup inputs arrive
  asynchronously and are synchronised here; the tick and lock flags
  come from logic on core_clk_i.
*/
//
// Operation
// - The self-clock flag sets whenever the self-clock status changes, either way.
// - The self-clock flag clears only on a write of one; a zero leaves it alone.
// - A set self-clock flag with its enable high raises the interrupt.
// - Flag bit 0 is read-only: 0 on crystal clock, 1 in self-clock mode on the PLL.
// - The interrupt-enable register sits at 0x4 and is read/write at any time.
// - Enable bit 7 gates the periodic tick interrupt.
// - Enable bit 4 gates the PLL lock interrupt.
// - Enable bit 1 is the self-clock interrupt enable; 0 suppresses it.
// - With the monitor disabled, clock loss starts no fallback and no reset; a check already running still restarts on it.
// - Monitor on and fallback off: a clock failure resets at once.
// - Monitor and fallback on: failure in wait stays in wait, powers up, self-clocks, checks.
// - 4096 good crystal cycles pass the check; leave self-clock, PLL per wait setting.
// - A wakeup or external reset with a good crystal leaves wait on the crystal clock.
// - The self-clock event itself never ends wait mode.
// - Without recovery, quality checks repeat without limit while in wait.
// - Leaving wait on a failed crystal keeps self-clock mode and the checks running.
`timescale 1ns/1ns
`default_nettype none
module clock_supervisor
  import clock_supervisor_pkg::*;
#(
  parameter int CHECK_CYCLES = QUALITY_CHECK_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Clock sources and system events
  input  wire logic        crystal_fail_i,
  input  wire logic        crystal_tick_i,
  input  wire logic        wait_request_i,
  input  wire logic        wakeup_irq_i,
  input  wire logic        ext_reset_i,
  input  wire logic        periodic_tick_flag_i,
  input  wire logic        pll_locked_irq_flag_i,
  // Power and clock steering
  output logic             regulator_on_o,
  output logic             pll_on_o,
  output logic             use_pll_clock_o,
  output logic             in_wait_o,
  output logic             monitor_reset_o,
  output logic             reset_sequence_o,
  output logic             irq_o,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       tick_prev_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {crystal_fail_i, crystal_tick_i, wait_request_i, wakeup_irq_i, ext_reset_i};
      sync2_q <= sync1_q;
    end
  end

  logic fail_s;
  logic tick_s;
  logic wait_req_s;
  logic wakeup_s;
  logic ext_rst_s;
  assign {fail_s, tick_s, wait_req_s, wakeup_s, ext_rst_s} = sync2_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_prev_q <= 1'b0;
    end else begin
      tick_prev_q <= tick_s;
    end
  end

  // Crystal cycle counted on each rising edge of the slow tick
  logic tick_edge;
  assign tick_edge = tick_s & ~tick_prev_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]       irq_enable_q;
  clock_control_t   ctrl_q;
  logic             self_clock_irq_flag_q;
  logic             self_clock_status_q;
  logic             self_clock_status_prev_q;
  supervise_state_t state_q;
  logic [QUALITY_COUNT_W-1:0] check_count_q;
  logic             in_wait_q;
  logic             pll_on_q;
  logic             monitor_reset_q;
  logic             reset_seq_q;

  logic             wr_fire;
  logic [7:0]       wr_addr_q;
  logic [31:0]      wr_data_q;
  logic [3:0]       wr_strb_q;
  logic             aw_have_q;
  logic             w_have_q;

  logic self_clock_irq_enable;
  assign self_clock_irq_enable = irq_enable_q[SELF_CLOCK_FLAG_BIT];

  // Clock failure only seen while the monitor runs
  logic fail_seen;
  assign fail_seen = fail_s & ctrl_q.monitor_enable;

  // ---------------------------------------------------------------
  // Supervision state machine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q             <= ST_NORMAL;
      self_clock_status_q <= 1'b0;
      check_count_q       <= '0;
    end else begin
      case (state_q)
        ST_NORMAL: begin
          check_count_q <= '0;
          if (fail_seen && ctrl_q.fallback_enable) begin
            state_q             <= ST_FALLBACK_CHECK;
            self_clock_status_q <= 1'b1;
          end
        end
        ST_FALLBACK_CHECK: begin
          // Restart the check whenever the monitor reports failure again
          if (fail_s) begin
            check_count_q <= '0;
          end else if (tick_edge) begin
            if (32'(check_count_q) + 1 >= CHECK_CYCLES) begin
              state_q             <= ST_NORMAL;
              self_clock_status_q <= 1'b0;
              check_count_q       <= '0;
            end else begin
              check_count_q <= check_count_q + 1'b1;
            end
          end
        end
        default: begin
          state_q             <= ST_NORMAL;
          self_clock_status_q <= 1'b0;
        end
      endcase
    end
  end

  // Monitor reset fires at once when fallback is off
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor_reset_q <= 1'b0;
    end else begin
      monitor_reset_q <= fail_seen & ~ctrl_q.fallback_enable;
    end
  end

  // ---------------------------------------------------------------
  // Wait mode and power steering
  // ---------------------------------------------------------------
  // Only wakeup and external reset end wait; the self-clock event never does
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_wait_q   <= 1'b0;
      reset_seq_q <= 1'b0;
    end else begin
      reset_seq_q <= 1'b0;
      if (in_wait_q) begin
        if (wakeup_s || ext_rst_s) begin
          in_wait_q   <= 1'b0;
          reset_seq_q <= ext_rst_s;
        end
      end else if (wait_req_s) begin
        in_wait_q <= 1'b1;
      end
    end
  end

  // PLL on in run, on in self-clock, else off in wait if so configured
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_on_q <= 1'b1;
    end else begin
      pll_on_q <= self_clock_status_q | ~in_wait_q | ~ctrl_q.pll_off_in_wait;
    end
  end

  assign regulator_on_o   = 1'b1;
  assign pll_on_o         = pll_on_q;
  assign use_pll_clock_o  = self_clock_status_q;
  assign in_wait_o        = in_wait_q;
  assign monitor_reset_o  = monitor_reset_q;
  assign reset_sequence_o = reset_seq_q;

  // ---------------------------------------------------------------
  // Event flag and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      self_clock_status_prev_q <= 1'b0;
    end else begin
      self_clock_status_prev_q <= self_clock_status_q;
    end
  end

  logic status_changed;
  assign status_changed = self_clock_status_q ^ self_clock_status_prev_q;

  // Clear by writing one to flags or to the clear register; set wins
  logic flag_clear;
  assign flag_clear = wr_fire && wr_strb_q[0] && wr_data_q[SELF_CLOCK_FLAG_BIT]
                      && (wr_addr_q == FLAGS_ADDR || wr_addr_q == EVENT_CLEAR_ADDR);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      self_clock_irq_flag_q <= 1'b0;
    end else if (status_changed) begin
      self_clock_irq_flag_q <= 1'b1;
    end else if (flag_clear) begin
      self_clock_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (self_clock_irq_flag_q & self_clock_irq_enable)
             | (periodic_tick_flag_i & irq_enable_q[PERIODIC_FLAG_BIT])
             | (pll_locked_irq_flag_i & irq_enable_q[PLL_LOCKED_FLAG_BIT]);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      wr_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_have_q  <= 1'b0;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q  <= 1'b1;
      wr_data_q <= s_axi_wdata;
      wr_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  logic wr_mapped;
  assign wr_mapped = (wr_addr_q == FLAGS_ADDR) || (wr_addr_q == IRQ_ENABLE_ADDR)
                  || (wr_addr_q == CONTROL_ADDR) || (wr_addr_q == EVENT_CLEAR_ADDR)
                  || (wr_addr_q == STATE_ADDR);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable_q <= IRQ_ENABLE_RESET;
    end else if (wr_fire && wr_strb_q[0] && wr_addr_q == IRQ_ENABLE_ADDR) begin
      irq_enable_q <= wr_data_q[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= clock_control_t'(CONTROL_RESET[2:0]);
    end else if (wr_fire && wr_strb_q[0] && wr_addr_q == CONTROL_ADDR) begin
      ctrl_q.monitor_enable  <= wr_data_q[MONITOR_ENABLE_BIT];
      ctrl_q.fallback_enable <= wr_data_q[FALLBACK_ENABLE_BIT];
      ctrl_q.pll_off_in_wait <= wr_data_q[PLL_OFF_IN_WAIT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic [31:0] rd_value;
  logic        rd_mapped;

  always_comb begin
    rd_value  = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      FLAGS_ADDR: begin
        rd_value[SELF_CLOCK_STATUS_BIT] = self_clock_status_q;
        rd_value[SELF_CLOCK_FLAG_BIT]   = self_clock_irq_flag_q;
      end
      IRQ_ENABLE_ADDR: begin
        rd_value[7:0] = irq_enable_q;
      end
      CONTROL_ADDR: begin
        rd_value[MONITOR_ENABLE_BIT]  = ctrl_q.monitor_enable;
        rd_value[FALLBACK_ENABLE_BIT] = ctrl_q.fallback_enable;
        rd_value[PLL_OFF_IN_WAIT_BIT] = ctrl_q.pll_off_in_wait;
      end
      EVENT_CLEAR_ADDR: begin
        rd_value = 32'h0000_0000;
      end
      STATE_ADDR: begin
        rd_value[QUALITY_COUNT_W-1:0] = check_count_q;
        rd_value[16] = in_wait_q;
        rd_value[17] = pll_on_q;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // clock_supervisor
`default_nettype wire

// File: clock_supervisor_chk.sv
/* Port checker for the clock supervisor.
   Assumes a bind onto clock_supervisor and a single clock domain. */
`timescale 1ns/1ns
`default_nettype none
module clock_supervisor_chk (
  // Clock, reset and events
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic crystal_fail_i,
  input wire logic wakeup_irq_i,
  input wire logic ext_reset_i,
  // Steering outputs
  input wire logic regulator_on_o,
  input wire logic pll_on_o,
  input wire logic use_pll_clock_o,
  input wire logic in_wait_o,
  input wire logic monitor_reset_o,
  input wire logic reset_sequence_o,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------------------
  // Supervision
  // ------------------------------------------------------------
  chk_regulator_kept: assert property (regulator_on_o)
    else $error("regulator off");
  chk_pll_feeds_self: assert property (use_pll_clock_o && $past(use_pll_clock_o) |-> pll_on_o)
    else $error("self clock without pll");
  // Sync delay of the failure input is allowed for by several depths
  chk_self_entry: assert property ($rose(use_pll_clock_o) |->
    $past(crystal_fail_i, 2) || $past(crystal_fail_i, 3) || $past(crystal_fail_i, 4))
    else $error("self clock without failure");
  chk_self_exit: assert property ($fell(use_pll_clock_o) |->
    !$past(crystal_fail_i, 3) && !$past(crystal_fail_i, 8))
    else $error("self clock left during failure");
  chk_reset_cause: assert property (monitor_reset_o |->
    $past(crystal_fail_i, 2) || $past(crystal_fail_i, 3) || $past(crystal_fail_i, 4))
    else $error("monitor reset without failure");
  chk_wait_holds: assert property ((in_wait_o && !wakeup_irq_i && !ext_reset_i) [*5] |=> in_wait_o)
    else $error("wait left without wakeup");
  chk_reset_pulse: assert property (reset_sequence_o |-> $fell(in_wait_o) ##1 !reset_sequence_o)
    else $error("bad reset sequence pulse");
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
endmodule // clock_supervisor_chk
bind clock_supervisor clock_supervisor_chk clock_supervisor_chk_inst (.*);
`default_nettype wire

// File: crystal_source_model.sv
/* Crystal source model: slow tick and failure flag.
   Assumes the bench drives halt_i just after clock edges. */
`timescale 1ns/1ns
`default_nettype none
module crystal_source_model (
  // Clock and command
  input  wire logic core_clk_i,
  input  wire logic halt_i,
  // Toward the supervisor
  output logic      fail_o,
  output logic      tick_o
);
  logic [1:0] div_q = 2'h0;
  logic       tick_q = 1'b0;
  // Tick stands still while failed, as a dead crystal would
  always_ff @(posedge core_clk_i) begin
    if (!halt_i) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        tick_q <= ~tick_q;
      end
    end
  end
  assign tick_o = tick_q;
  assign fail_o = halt_i;
endmodule // crystal_source_model
`default_nettype wire

// File: clock_supervisor_tb.sv
/* Self-checking bench for the clock supervisor.
   Assumes the package, the crystal source model and the checker. */
`timescale 1ns/1ns
`default_nettype none
module clock_supervisor_tb
  import clock_supervisor_pkg::*;
;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, crystal_halt = 1'b0;
  logic        wait_request_i = 1'b0, wakeup_irq_i = 1'b0, ext_reset_i = 1'b0;
  logic        periodic_tick_flag_i = 1'b0, pll_locked_irq_flag_i = 1'b0;
  logic        crystal_fail_i, crystal_tick_i, irq_o, seen_pulse;
  logic        regulator_on_o, pll_on_o, use_pll_clock_o, in_wait_o;
  logic        monitor_reset_o, reset_sequence_o;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bus_resp;
  int          bad_count = 0, comparisons = 0;

  clock_supervisor #(.CHECK_CYCLES(8)) clock_supervisor_inst (.*);
  crystal_source_model crystal_source_model_inst (.core_clk_i, .halt_i(crystal_halt),
    .fail_o(crystal_fail_i), .tick_o(crystal_tick_i));

  initial forever #25 core_clk_i = ~core_clk_i;
  // ------------------------------------------------------------
  // Common tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Packs wait, self clock, pll and regulator outputs, high to low
  function automatic logic [31:0] st();
    return {28'h0000000, in_wait_o, use_pll_clock_o, pll_on_o, regulator_on_o};
  endfunction
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    bus_resp = s_axi_bresp;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    bus_resp = s_axi_rresp;
    check(what, s_axi_rdata, exp);
  endtask
  task automatic wait_pll(input logic v);
    int n;
    n = 0;
    while (use_pll_clock_o !== v && n < 300) begin
      @(posedge core_clk_i);
      n++;
    end
    check("pll clock wait", {31'h00000000, use_pll_clock_o}, {31'h00000000, v});
  endtask
  task automatic enter_wait();
    wait_request_i <= 1'b1;
    cycles(4);
    wait_request_i <= 1'b0;
    cycles(2);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_registers();
    rdchk(IRQ_ENABLE_ADDR, {24'h000000, IRQ_ENABLE_RESET}, "enable reset");
    wr(IRQ_ENABLE_ADDR, 32'h00000092);
    rdchk(IRQ_ENABLE_ADDR, 32'h00000092, "enable readback");
    wr(FLAGS_ADDR, 32'h00000003);
    rdchk(FLAGS_ADDR, 32'h00000000, "flags written");
    wr(8'h14, 32'h00000001);
    check("unmapped write", {30'h00000000, bus_resp}, {30'h00000000, RESP_SLVERR});
    rdchk(8'h14, 32'h00000000, "unmapped read");
    check("unmapped read resp", {30'h00000000, bus_resp}, {30'h00000000, RESP_SLVERR});
    wr(IRQ_ENABLE_ADDR, 32'h00000000);
  endtask
  task automatic t_irq_gates();
    for (int i = 0; i < 2; i++) begin
      periodic_tick_flag_i <= (i == 0);
      pll_locked_irq_flag_i <= (i == 1);
      cycles(4);
      check("irq masked", {31'h00000000, irq_o}, 32'h00000000);
      wr(IRQ_ENABLE_ADDR, 32'h00000001 << (i == 0 ? PERIODIC_FLAG_BIT : PLL_LOCKED_FLAG_BIT));
      cycles(3);
      check("irq enabled", {31'h00000000, irq_o}, 32'h00000001);
      wr(IRQ_ENABLE_ADDR, 32'h00000002);
      cycles(3);
      check("irq other enable", {31'h00000000, irq_o}, 32'h00000000);
    end
    periodic_tick_flag_i <= 1'b0;
    pll_locked_irq_flag_i <= 1'b0;
    wr(IRQ_ENABLE_ADDR, 32'h00000000);
  endtask
  task automatic t_monitor_modes();
    wr(CONTROL_ADDR, 32'h00000000);
    crystal_halt <= 1'b1;
    cycles(20);
    check("state monitor off", st(), 32'h00000003);
    check("reset monitor off", {31'h00000000, monitor_reset_o}, 32'h00000000);
    rdchk(FLAGS_ADDR, 32'h00000000, "flags monitor off");
    crystal_halt <= 1'b0;
    cycles(6);
    wr(CONTROL_ADDR, 32'h00000001);
    crystal_halt <= 1'b1;
    cycles(6);
    check("monitor reset", {31'h00000000, monitor_reset_o}, 32'h00000001);
    check("state on reset", st(), 32'h00000003);
    crystal_halt <= 1'b0;
    cycles(6);
    check("monitor reset end", {31'h00000000, monitor_reset_o}, 32'h00000000);
  endtask
  task automatic t_fallback_recover();
    wr(CONTROL_ADDR, 32'h00000007);
    enter_wait();
    crystal_halt <= 1'b1;
    wait_pll(1'b1);
    cycles(3);
    check("self clock in wait", st(), 32'h0000000F);
    check("irq enable low", {31'h00000000, irq_o}, 32'h00000000);
    rdchk(FLAGS_ADDR, 32'h00000003, "flags on loss");
    wr(FLAGS_ADDR, 32'h00000001);
    rdchk(FLAGS_ADDR, 32'h00000003, "flag zero write");
    wr(FLAGS_ADDR, 32'h00000002);
    rdchk(FLAGS_ADDR, 32'h00000001, "flag cleared");
    crystal_halt <= 1'b0;
    wait_pll(1'b0);
    cycles(3);
    check("recovered in wait", st(), 32'h00000009);
    rdchk(FLAGS_ADDR, 32'h00000002, "flags on recovery");
    wakeup_irq_i <= 1'b1;
    cycles(4);
    wakeup_irq_i <= 1'b0;
    cycles(3);
    check("woken on crystal", st(), 32'h00000003);
    wr(FLAGS_ADDR, 32'h00000002);
  endtask
  task automatic t_no_recovery();
    wr(CONTROL_ADDR, 32'h00000003);
    enter_wait();
    check("pll kept in wait", st(), 32'h0000000B);
    crystal_halt <= 1'b1;
    wait_pll(1'b1);
    cycles(150);
    check("checks repeat", st(), 32'h0000000F);
    rdchk(STATE_ADDR, 32'h00030000, "state in fallback");
    ext_reset_i <= 1'b1;
    seen_pulse = 1'b0;
    repeat (6) begin
      @(posedge core_clk_i);
      seen_pulse |= reset_sequence_o;
    end
    ext_reset_i <= 1'b0;
    check("reset sequence", {31'h00000000, seen_pulse}, 32'h00000001);
    check("awake on pll", st(), 32'h00000007);
    wr(IRQ_ENABLE_ADDR, 32'h00000002);
    cycles(3);
    check("self clock irq", {31'h00000000, irq_o}, 32'h00000001);
    crystal_halt <= 1'b0;
    wait_pll(1'b0);
    cycles(3);
    check("late recovery", st(), 32'h00000003);
    wr(EVENT_CLEAR_ADDR, 32'h00000002);
    cycles(3);
    check("irq after clear", {31'h00000000, irq_o}, 32'h00000000);
  endtask
  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_registers();
    t_irq_gates();
    t_monitor_modes();
    t_fallback_recover();
    t_no_recovery();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    conclude();
  end
endmodule // clock_supervisor_tb
`default_nettype wire
